// *** baud_if.sv ***
// Link between the port core and its bit-rate divider.
// Assumes both ends share the bus clock.
`timescale 1ns/1ps
`default_nettype none
interface baud_if;
	logic [2:0] prescale_select;
	logic [2:0] rate_select;
	logic       run;
	logic       tick;

	modport ctrl (output prescale_select, output rate_select, output run, input tick);
	modport gen  (input prescale_select, input rate_select, input run, output tick);
endinterface
`default_nettype wire

// *** spi_baud_gen.sv ***
// Master bit-rate divider: one tick per serial clock edge.
// Assumes settings stay stable while run is high.
`timescale 1ns/1ps
`default_nettype none
module spi_baud_gen (
	input  wire logic clock_i,
	input  wire logic rst_n,
	baud_if.gen       bus
);
	import spi_pkg::*;

	logic [2:0] pre_cnt_r;
	logic [6:0] half_cnt_r;
	logic [6:0] half_last;
	logic       pre_done;

	// Half bit period is prescale divisor times half the rate divisor
	assign half_last = 7'((8'h01 << bus.rate_select) - 8'h01);
	assign pre_done  = (pre_cnt_r == bus.prescale_select);
	assign bus.tick  = bus.run && pre_done && (half_cnt_r == half_last);

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_r <= 3'h0;
		end else if (!bus.run || pre_done) begin
			pre_cnt_r <= 3'h0;
		end else begin
			pre_cnt_r <= pre_cnt_r + 3'h1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			half_cnt_r <= 7'h00;
		end else if (!bus.run || bus.tick) begin
			half_cnt_r <= 7'h00;
		end else if (pre_done) begin
			half_cnt_r <= half_cnt_r + 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	slow_tick_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		bus.tick && bus.prescale_select != 3'h0 |=> !bus.tick)
		else $error("Bit clock edge faster than prescale allows");

	rate_tick_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		bus.tick && bus.rate_select == 3'h1 && bus.prescale_select == 3'h0
		&& bus.run ##1 bus.run |-> !bus.tick)
		else $error("Rate divide by four ticks too early");
endmodule
`default_nettype wire

// *** spi_peer.sv ***
// Far-side peripheral model: a slave that swaps one byte per frame.
// Assumes select and clock change on bus clock edges, half period >= 2.
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
	input  wire logic           clock_i,
	input  wire logic           sck_i,
	input  wire logic           ss_n_i,
	input  wire logic           mosi_i,
	input  wire logic           clock_idle_level_i,
	input  wire logic           clock_edge_phase_i,
	input  wire logic           lsb_first_i,
	input  wire spi_pkg::byte_t tx_byte_i,
	output logic                miso_o,
	output var spi_pkg::byte_t  rx_byte_o,
	output logic                done_o
);
	import spi_pkg::*;
	byte_t      sh_r   = 8'h00;
	logic [3:0] edge_r = 4'h0;
	logic       sck_r  = 1'b0;
	logic       ss_r   = 1'b1;
	logic       alt_r  = 1'b0;
	logic       mosi_r = 1'b0;

	initial done_o = 1'b0;
	// Released line shows a changing pattern, never the last bit
	assign miso_o = ss_n_i ? alt_r : (lsb_first_i ? sh_r[0] : sh_r[7]);
	always @(posedge clock_i) begin
		sck_r  <= sck_i;
		ss_r   <= ss_n_i;
		alt_r  <= ~alt_r;
		mosi_r <= mosi_i;
		done_o <= 1'b0;
		// An edge is seen a cycle late, so select and data are taken as they stood before it
		if (!ss_n_i && ss_r) begin
			sh_r   <= tx_byte_i;
			edge_r <= 4'h0;
		end else if (!ss_r && sck_i != sck_r) begin
			edge_r <= edge_r + 4'h1;
			// Even edges sample in phase 0, odd edges in phase 1
			if (edge_r[0] == clock_edge_phase_i) begin
				rx_byte_o <= lsb_first_i ? {mosi_r, rx_byte_o[7:1]} : {rx_byte_o[6:0], mosi_r};
			end else if (edge_r != 4'h0) begin
				sh_r <= lsb_first_i ? {1'b0, sh_r[7:1]} : {sh_r[6:0], 1'b0};
			end
			if (edge_r == 4'hF) begin
				sh_r   <= tx_byte_i;
				done_o <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** spi_pkg.sv ***
// Constants, register map and types shared by the serial port design.
// Assumes a single 25 MHz bus clock and byte-wide software registers.
package spi_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [2:0] addr_t;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam addr_t OFS_CTRL1  = 3'h0;
	localparam addr_t OFS_CTRL2  = 3'h1;
	localparam addr_t OFS_BAUD   = 3'h2;
	localparam addr_t OFS_STATUS = 3'h3;
	localparam addr_t OFS_DATA   = 3'h4;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int C1_ENABLE  = 6;
	localparam int C1_MASTER  = 4;
	localparam int C1_CLOCK_IDLE_LEVEL    = 3;
	localparam int C1_CLOCK_EDGE_PHASE    = 2;
	localparam int C1_SEL_OUT = 1;
	localparam int C1_LSBF    = 0;
	localparam int C2_FAULT_EN = 4;
	localparam int C2_DIR_OUT  = 3;
	localparam int C2_SWIRE   = 0;
	localparam int BD_PRE_LO  = 4;
	localparam int BD_RATE_LO = 0;
	localparam int ST_RXFULL  = 7;
	localparam int ST_TXEMPTY = 5;
	localparam int ST_FAULT   = 4;

	// Writable bits of each control register
	localparam byte_t CTRL1_MASK = 8'hFF;
	localparam byte_t CTRL2_MASK = 8'h1B;
	localparam byte_t BAUD_MASK  = 8'h77;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam byte_t CTRL1_RST  = 8'h04;
	localparam byte_t CTRL2_RST  = 8'h00;
	localparam byte_t BAUD_RST   = 8'h00;
	localparam byte_t DATA_RST   = 8'h00;
	localparam logic [3:0] LAST_EDGE = 4'hF;

	// Transfer engine states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_XFER = 2'b10
	} xfer_state_t;

endpackage

// *** spi_port.sv ***
// Serial peripheral port, master or slave, with byte-wide registers.
// Assumes pin inputs synchronous to clock_i and pad muxing outside.
//
// What this block does
// - Master bit rate at most bus clock/2
// - Master starts; shift registers exchange contents
// - Master drives clock, MOSI out, MISO in
// - Slave clocked by pin, MISO out, MOSI in
// - Written byte waits, loaded at transfer start
// - Finished byte moves to receive buffer unless it is still full
// - Prescaler divides bus clock by 1..8
// - Rate select divides further by 2..256
// - Disabled port drives none of four pins
// - Two-wire mode uses both data pins normally
// - Single-wire master uses MOSI, frees MISO
// - Single-wire slave uses MISO, frees MOSI
// - Bidir output enable sets shared pin direction
// - Master select pin: free, fault input, output
// - Stop disables port; deep stop resets it
// - Light stop holds state and resumes
// - Five byte-wide software registers
// - Disable aborts, empties buffers, resets flags
// - Clock idle level follows polarity bit
// - Phase picks mid-bit or start-bit first edge
// - Low-bit-first control selects shift order
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module spi_port (
	input  wire logic          clock_i,
	input  wire logic          reset_n_i,
	input  wire spi_pkg::addr_t addr_i,
	input  wire spi_pkg::byte_t wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output var  spi_pkg::byte_t rdata_o,
	input  wire logic          stop3_i,
	input  wire logic          deep_stop_i,
	input  wire logic          sck_i,
	output logic               sck_o,
	output logic               sck_oe_n_o,
	input  wire logic          mosi_i,
	output logic               mosi_o,
	output logic               mosi_oe_n_o,
	input  wire logic          miso_i,
	output logic               miso_o,
	output logic               miso_oe_n_o,
	input  wire logic          ss_n_i,
	output logic               ss_n_o,
	output logic               ss_oe_n_o
);
	import spi_pkg::*;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// Frozen clocks in light stop, full wipe in deep stop
	logic run;
	logic wipe;
	assign run  = !stop3_i;
	assign wipe = deep_stop_i;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	byte_t ctrl1_r;
	byte_t ctrl2_r;
	byte_t baud_r;
	byte_t tx_buf_r;
	byte_t rx_buf_r;
	logic  tx_empty_r;
	logic  rx_full_r;
	logic  fault_r;
	logic  fault_armed_r;

	logic enable, master, clock_idle_level, clock_edge_phase, sel_out_en, lsbf, fault_en, dir_out, swire;
	assign enable  = ctrl1_r[C1_ENABLE] && !stop3_i && !deep_stop_i;
	assign master  = ctrl1_r[C1_MASTER];
	assign clock_idle_level    = ctrl1_r[C1_CLOCK_IDLE_LEVEL];
	assign clock_edge_phase    = ctrl1_r[C1_CLOCK_EDGE_PHASE];
	assign sel_out_en = ctrl1_r[C1_SEL_OUT];
	assign lsbf       = ctrl1_r[C1_LSBF];
	assign fault_en   = ctrl2_r[C2_FAULT_EN];
	assign dir_out    = ctrl2_r[C2_DIR_OUT];
	assign swire   = ctrl2_r[C2_SWIRE];

	logic wr_c1, wr_c2, wr_bd, wr_data, rd_st, rd_data;
	assign wr_c1   = wr_i && run && addr_i == OFS_CTRL1;
	assign wr_c2   = wr_i && run && addr_i == OFS_CTRL2;
	assign wr_bd   = wr_i && run && addr_i == OFS_BAUD;
	assign wr_data = wr_i && run && addr_i == OFS_DATA;
	assign rd_st   = rd_i && run && addr_i == OFS_STATUS;
	assign rd_data = rd_i && run && addr_i == OFS_DATA;

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_r <= CTRL1_RST;
			ctrl2_r <= CTRL2_RST;
			baud_r  <= BAUD_RST;
		end else if (wipe) begin
			ctrl1_r <= CTRL1_RST;
			ctrl2_r <= CTRL2_RST;
			baud_r  <= BAUD_RST;
		end else begin
			if (wr_c1) begin
				ctrl1_r <= wdata_i & CTRL1_MASK;
			end
			if (wr_c2) begin
				ctrl2_r <= wdata_i & CTRL2_MASK;
			end
			if (wr_bd) begin
				baud_r <= wdata_i & BAUD_MASK;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transfer engine
	// ----------------------------------------------------------------
	xfer_state_t state_r;
	byte_t       shift_r;
	logic [3:0]  edge_cnt_r;
	logic        in_bit_r;
	logic        sck_r;
	logic        sck_prev_r;
	baud_if      baud ();

	logic busy, fault_in, ss_auto, slave_sel, din, edge_ev, sample, do_shift, last;
	logic shift_bit, start_m, start_s, start, abort;
	byte_t shifted;

	assign busy      = (state_r == ST_XFER);
	assign fault_in  = enable && master && fault_en && !sel_out_en;
	assign ss_auto   = enable && master && fault_en && sel_out_en;
	assign slave_sel = enable && !master && !ss_n_i;
	assign din       = master ? (swire ? mosi_i : miso_i)
	                          : (swire ? miso_i : mosi_i);
	assign baud.prescale_select = baud_r[BD_PRE_LO +: 3];
	assign baud.rate_select     = baud_r[BD_RATE_LO +: 3];
	assign baud.run             = run && busy && master;

	// Master edges come from the divider, slave edges from the pin
	assign edge_ev  = run && busy && (master ? baud.tick : (sck_i != sck_prev_r));
	assign last     = edge_ev && edge_cnt_r == LAST_EDGE;
	assign sample   = edge_ev && (edge_cnt_r[0] == clock_edge_phase);
	assign do_shift = edge_ev && ((edge_cnt_r[0] != clock_edge_phase && !(clock_edge_phase && edge_cnt_r == 4'h0))
	                  || (last && clock_edge_phase));
	assign shift_bit = (last && clock_edge_phase) ? din : in_bit_r;
	assign shifted   = lsbf ? {shift_bit, shift_r[7:1]} : {shift_r[6:0], shift_bit};

	assign start_m = enable && master && !tx_empty_r && !fault_r && !busy;
	assign start_s = slave_sel && !busy;
	assign start   = run && (start_m || start_s);
	// Halted clocks abort nothing, so a light stop resumes mid-byte
	assign abort   = run && (!enable || (master && fault_r) || (!master && busy && ss_n_i));

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
		end else if (wipe || abort) begin
			state_r <= ST_IDLE;
		end else if (run) begin
			case (state_r)
				ST_IDLE: begin
					if (start) begin
						state_r <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (last) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			edge_cnt_r <= 4'h0;
		end else if (wipe || abort || start) begin
			edge_cnt_r <= 4'h0;
		end else if (edge_ev) begin
			edge_cnt_r <= edge_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			shift_r  <= DATA_RST;
			in_bit_r <= 1'b0;
		end else if (wipe || (run && !enable)) begin
			shift_r  <= DATA_RST;
			in_bit_r <= 1'b0;
		end else if (start) begin
			shift_r <= tx_buf_r;
		end else begin
			if (sample) begin
				in_bit_r <= din;
			end
			if (do_shift) begin
				shift_r <= shifted;
			end
		end
	end

	// Serial clock toggles once per edge and rests at its idle level
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sck_r <= 1'b0;
		end else if (wipe || !busy || abort) begin
			sck_r <= clock_idle_level;
		end else if (edge_ev && master) begin
			sck_r <= !sck_r;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sck_prev_r <= 1'b0;
		end else if (run) begin
			sck_prev_r <= sck_i;
		end
	end

	// ----------------------------------------------------------------
	// Buffers and flags
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_buf_r   <= DATA_RST;
			tx_empty_r <= 1'b1;
		end else if (wipe || (run && !enable)) begin
			tx_buf_r   <= DATA_RST;
			tx_empty_r <= 1'b1;
		end else if (wr_data) begin
			tx_buf_r   <= wdata_i;
			tx_empty_r <= 1'b0;
		end else if (start) begin
			tx_empty_r <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_buf_r  <= DATA_RST;
			rx_full_r <= 1'b0;
		end else if (wipe || (run && !enable)) begin
			rx_buf_r  <= DATA_RST;
			rx_full_r <= 1'b0;
		end else if (last && !rx_full_r) begin
			rx_buf_r  <= shifted;
			rx_full_r <= 1'b1;
		end else if (last) begin
			rx_full_r <= 1'b1;
		end else if (rd_data) begin
			rx_full_r <= 1'b0;
		end
	end

	// Fault clears by a status read with the flag set, then an OFS_CTRL1 write
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			fault_r       <= 1'b0;
			fault_armed_r <= 1'b0;
		end else if (wipe || (run && !enable)) begin
			fault_r       <= 1'b0;
			fault_armed_r <= 1'b0;
		end else if (run) begin
			if (fault_in && !ss_n_i) begin
				fault_r <= 1'b1;
			end else if (wr_c1 && fault_armed_r) begin
				fault_r <= 1'b0;
			end
			if (rd_st) begin
				fault_armed_r <= fault_r;
			end else if (wr_c1) begin
				fault_armed_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	byte_t status;
	always_comb begin
		status             = 8'h00;
		status[ST_RXFULL]  = rx_full_r;
		status[ST_TXEMPTY] = tx_empty_r;
		status[ST_FAULT]   = fault_r;
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_o <= 8'h00;
		end else if (rd_i && run) begin
			case (addr_i)
				OFS_CTRL1:  rdata_o <= ctrl1_r;
				OFS_CTRL2:  rdata_o <= ctrl2_r;
				OFS_BAUD:   rdata_o <= baud_r;
				OFS_STATUS: rdata_o <= status;
				OFS_DATA:   rdata_o <= rx_buf_r;
				default:    rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	logic m_drive, s_drive, data_out;
	assign m_drive  = enable && master && !fault_r;
	assign s_drive  = slave_sel;
	assign data_out = lsbf ? shift_r[0] : shift_r[7];

	always_comb begin
		sck_o       = sck_r;
		mosi_o      = data_out;
		miso_o      = data_out;
		ss_n_o      = !busy;
		sck_oe_n_o  = !m_drive;
		mosi_oe_n_o = 1'b1;
		miso_oe_n_o = 1'b1;
		ss_oe_n_o   = !(ss_auto && !fault_r);
		if (m_drive) begin
			mosi_oe_n_o = swire ? !dir_out : 1'b0;
		end
		if (s_drive) begin
			miso_oe_n_o = swire ? !dir_out : 1'b0;
		end
		if (!enable) begin
			sck_oe_n_o  = 1'b1;
			mosi_oe_n_o = 1'b1;
			miso_oe_n_o = 1'b1;
			ss_oe_n_o   = 1'b1;
		end
	end

	spi_baud_gen baud_gen (
		.clock_i (clock_i),
		.rst_n   (rst_n),
		.bus     (baud.gen)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence load_seq;
		start && run && !(wipe || abort);
	endsequence

	sequence byte_seq;
		last && !rx_full_r && !wipe && enable;
	endsequence

	released_pins_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		!enable |-> sck_oe_n_o && mosi_oe_n_o && miso_oe_n_o && ss_oe_n_o)
		else $error("Disabled port drives a pin");

	tx_load_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		load_seq |=> shift_r == $past(tx_buf_r) && tx_empty_r)
		else $error("Transmit byte not moved into shifter");

	rx_store_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		byte_seq |=> rx_full_r && rx_buf_r == $past(shifted))
		else $error("Received byte not stored");

	disable_flags_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		$fell(ctrl1_r[C1_ENABLE]) && !stop3_i |=> tx_empty_r && !rx_full_r && !busy)
		else $error("Disable did not clear the engine");

	sck_idle_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		!busy && $past(!busy) && $stable(clock_idle_level) |-> sck_o == clock_idle_level)
		else $error("Serial clock not at idle level");

	auto_select_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		ss_auto && !fault_r |-> !ss_oe_n_o && (ss_n_o == !busy))
		else $error("Automatic select wrong");

	fault_stop_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		fault_in && !ss_n_i && run && !wipe |=> fault_r ##0 sck_oe_n_o && mosi_oe_n_o)
		else $error("Mode fault did not stop driving");

	bidir_pin_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		enable && master && swire && !fault_r |-> miso_oe_n_o && (mosi_oe_n_o == !dir_out))
		else $error("Single-wire master pin use wrong");

	slave_pin_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		enable && !master && swire |-> mosi_oe_n_o && sck_oe_n_o)
		else $error("Single-wire slave pin use wrong");

	hold_stop_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		stop3_i && !deep_stop_i |=> $stable(shift_r) && $stable(edge_cnt_r) && $stable(ctrl1_r))
		else $error("State changed while clocks halted");
endmodule
`default_nettype wire

// *** spi_port_tb.sv ***
// Self-checking bench for the serial port against the peer model.
// Assumes the package, the design and the peer model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module spi_port_tb;
	import spi_pkg::*;
	// ----
	// Signals
	// ----
	logic  clock_i     = 1'b0;
	logic  reset_n_i   = 1'b0;
	logic  wr_i        = 1'b0;
	logic  rd_i        = 1'b0;
	logic  stop3_i     = 1'b0;
	logic  deep_stop_i = 1'b0;
	logic  tb_sck      = 1'b0;
	logic  tb_mosi     = 1'b0;
	logic  tb_ss       = 1'b1;
	logic  clock_idle_level        = 1'b0;
	logic  clock_edge_phase        = 1'b0;
	logic  lsbf        = 1'b0;
	logic  rd_seen     = 1'b0;
	addr_t addr_i      = 3'h0;
	byte_t wdata_i     = 8'h00;
	byte_t peer_tx     = 8'h00;
	byte_t rdata_o, peer_rx, q, ds, dm;
	logic  sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o;
	logic  ss_n_o, ss_oe_n_o, peer_miso, peer_done, sck_p, mosi_p, miso_p, ss_p;
	byte_t rd_q[$];
	byte_t peer_q[$];
	int    num_errors = 0;
	int    num_checks = 0;
	int    cycles     = 0;

	always #20 clock_i = ~clock_i;
	assign sck_p  = sck_oe_n_o ? tb_sck : sck_o;
	assign mosi_p = mosi_oe_n_o ? tb_mosi : mosi_o;
	assign miso_p = miso_oe_n_o ? peer_miso : miso_o;
	assign ss_p   = ss_oe_n_o ? tb_ss : ss_n_o;

	spi_port i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .stop3_i(stop3_i),
		.deep_stop_i(deep_stop_i), .sck_i(sck_p), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o),
		.mosi_i(mosi_p), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o), .miso_i(miso_p),
		.miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .ss_n_i(ss_p), .ss_n_o(ss_n_o),
		.ss_oe_n_o(ss_oe_n_o));
	spi_peer i_peer (.clock_i(clock_i), .sck_i(sck_p), .ss_n_i(ss_p), .mosi_i(mosi_p),
		.clock_idle_level_i(clock_idle_level), .clock_edge_phase_i(clock_edge_phase), .lsb_first_i(lsbf), .tx_byte_i(peer_tx),
		.miso_o(peer_miso), .rx_byte_o(peer_rx), .done_o(peer_done));

	// ----
	// Checking and bus tasks
	// ----
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input byte_t exp, input byte_t got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	always @(posedge clock_i) rd_seen <= rd_i && !stop3_i;
	always @(negedge clock_i) begin
		if (rd_seen) chk("rdata", rd_q.pop_front(), rdata_o);
		if (peer_done && peer_q.size() > 0) chk("peer_rx", peer_q.pop_front(), peer_rx);
	end
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			num_errors++;
			$display("Error timeout expected done seen hung");
			finish_test();
		end
	end
	task automatic wr(input addr_t a, input byte_t d);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input addr_t a, input byte_t exp);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		rd_q.push_back(exp);
		@(posedge clock_i);
		rd_i <= 1'b0;
	endtask
	task automatic master_xfer(input byte_t c1, input bit two);
		byte_t d;
		int    p;
		int    r;
		int    t0;
		int    dt;
		p = $urandom_range(3, 0);
		r = $urandom_range(2, 1);
		d = $urandom;
		peer_tx <= $urandom;
		clock_idle_level    <= c1[C1_CLOCK_IDLE_LEVEL];
		clock_edge_phase    <= c1[C1_CLOCK_EDGE_PHASE];
		lsbf    <= c1[C1_LSBF];
		wr(OFS_BAUD, byte_t'((p << BD_PRE_LO) | r));
		wr(OFS_CTRL1, c1);
		repeat (2) @(negedge clock_i);
		chk("sck_idle", {7'h0, c1[C1_CLOCK_IDLE_LEVEL]}, {7'h0, sck_p});
		peer_q.push_back(d);
		wr(OFS_DATA, d);
		t0 = cycles;
		repeat (2) @(negedge clock_i);
		chk("master_pins", 8'h02, {4'h0, ss_p, sck_oe_n_o, miso_oe_n_o, mosi_oe_n_o});
		if (two) begin
			peer_q.push_back(~d);
			wr(OFS_DATA, ~d);
			rd(OFS_STATUS, 8'h00);
		end
		while (peer_q.size() > 0 && cycles - t0 < 5000) @(negedge clock_i);
		dt = cycles - t0 - 2 - (two ? 32 : 16) * ((p + 1) << r);
		chk("frame_len", 8'h01, {7'h0, dt >= -5 && dt <= 5});
		rd(OFS_STATUS, 8'hA0);
		rd(OFS_DATA, peer_tx);
		rd(OFS_STATUS, 8'h20);
	endtask
	task automatic slave_xfer(input byte_t d, output byte_t qo);
		tb_ss <= 1'b0;
		repeat (4) @(negedge clock_i);
		chk("slave_pins", 8'h06, {5'h0, sck_oe_n_o, mosi_oe_n_o, miso_oe_n_o});
		for (int i = 7; i >= 0; i--) begin
			@(posedge clock_i);
			tb_mosi <= d[i];
			repeat (3) @(negedge clock_i);
			qo[i] = miso_p;
			@(posedge clock_i);
			tb_sck <= 1'b1;
			repeat (4) @(posedge clock_i);
			tb_sck <= 1'b0;
		end
		repeat (4) @(posedge clock_i);
		tb_ss   <= 1'b1;
		tb_mosi <= ~tb_mosi;
	endtask

	// ----
	// Tests
	// ----
	initial begin
		byte_t rst_tab [6];
		rst_tab = '{CTRL1_RST, CTRL2_RST, BAUD_RST, 8'h20, DATA_RST, 8'h00};
		void'($urandom(32'hd889));
		repeat (4) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (3) @(negedge clock_i);
		chk("idle_pins", 8'h0F, {4'h0, sck_oe_n_o, mosi_oe_n_o, miso_oe_n_o, ss_oe_n_o});
		for (int i = 0; i < 6; i++) rd(addr_t'(i), rst_tab[i]);
		wr(OFS_CTRL2, 8'hFF);
		rd(OFS_CTRL2, 8'h1B);
		wr(OFS_BAUD, 8'hFF);
		rd(OFS_BAUD, 8'h77);
		wr(OFS_STATUS, 8'h00);
		wr(3'h5, 8'hFF);
		rd(OFS_STATUS, 8'h20);
		rd(3'h5, 8'h00);
		$display("test registers done");
		wr(OFS_CTRL2, 8'h10);
		for (int m = 0; m < 8; m++) master_xfer(byte_t'(8'h52 | ((m & 6) << 1) | (m & 1)), m == 7);
		$display("test master done");
		wr(OFS_CTRL1, 8'h50);
		tb_ss <= 1'b0;
		repeat (3) @(negedge clock_i);
		chk("fault_release", 8'h03, {6'h0, sck_oe_n_o, mosi_oe_n_o});
		rd(OFS_STATUS, 8'h30);
		tb_ss <= 1'b1;
		wr(OFS_CTRL1, 8'h50);
		rd(OFS_STATUS, 8'h20);
		wr(OFS_CTRL2, 8'h00);
		tb_ss <= 1'b0;
		rd(OFS_STATUS, 8'h20);
		chk("ss_free", 8'h01, {7'h0, ss_oe_n_o});
		tb_ss <= 1'b1;
		$display("test fault done");
		wr(OFS_CTRL2, 8'h19);
		wr(OFS_CTRL1, 8'h52);
		wr(OFS_BAUD, 8'h77);
		wr(OFS_DATA, 8'h5A);
		repeat (3) @(negedge clock_i);
		chk("wire_master", 8'h01, {6'h0, mosi_oe_n_o, miso_oe_n_o});
		wr(OFS_CTRL2, 8'h11);
		@(negedge clock_i);
		chk("wire_input", 8'h01, {7'h0, mosi_oe_n_o});
		wr(OFS_CTRL1, 8'h12);
		@(negedge clock_i);
		chk("off_pins", 8'h0F, {4'h0, sck_oe_n_o, mosi_oe_n_o, miso_oe_n_o, ss_oe_n_o});
		rd(OFS_STATUS, 8'h20);
		$display("test disable done");
		ds = $urandom;
		dm = $urandom;
		wr(OFS_CTRL2, 8'h00);
		wr(OFS_CTRL1, 8'h40);
		wr(OFS_DATA, ds);
		slave_xfer(dm, q);
		chk("slave_out", ds, q);
		rd(OFS_STATUS, 8'hA0);
		rd(OFS_DATA, dm);
		wr(OFS_CTRL2, 8'h09);
		tb_ss <= 1'b0;
		repeat (3) @(negedge clock_i);
		chk("wire_slave", 8'h02, {6'h0, mosi_oe_n_o, miso_oe_n_o});
		@(posedge clock_i);
		tb_ss <= 1'b1;
		$display("test slave done");
		wr(OFS_CTRL2, 8'h10);
		wr(OFS_CTRL1, 8'h52);
		wr(OFS_BAUD, 8'h35);
		stop3_i <= 1'b1;
		repeat (2) @(negedge clock_i);
		chk("stop_pins", 8'h03, {6'h0, sck_oe_n_o, ss_oe_n_o});
		@(posedge clock_i);
		stop3_i <= 1'b0;
		rd(OFS_BAUD, 8'h35);
		@(posedge clock_i);
		deep_stop_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		deep_stop_i <= 1'b0;
		rd(OFS_BAUD, BAUD_RST);
		rd(OFS_CTRL1, CTRL1_RST);
		@(posedge clock_i);
		$display("test stop done");
		finish_test();
	end
endmodule
`default_nettype wire
